// [dv/chain_host_model.sv]
// Host transmitter model driving the lower receive pins.
`timescale 1ns/1ps
module chain_host_model (
  input wire clk,
  input wire arst_n,
  input wire go,
  input wire [11:0] frame,
  input wire [6:0] bit_cyc,
  input wire single_ended,
  output reg busy,
  output wire mid,
  output reg [3:0] idx,
  output wire rx_p,
  output wire rx_n
);
  reg [12:0] sh;
  reg [6:0] cnt;
  // Idle drives both pins low; a mark bit leads each character out of idle.
  assign rx_p = busy & ~single_ended & sh[0];
  assign rx_n = busy & ~sh[0];
  assign mid = busy && (cnt == (bit_cyc >> 1));
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      sh <= 13'h0;
      cnt <= 7'h0;
      idx <= 4'h0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      sh <= {frame, 1'b1};
      cnt <= 7'h0;
      idx <= 4'h0;
    end else if (busy && cnt == bit_cyc - 7'd1) begin
      cnt <= 7'h0;
      sh <= sh >> 1;
      idx <= idx + 4'd1;
      busy <= (idx != 4'd12);
    end else if (busy) begin
      cnt <= cnt + 7'd1;
    end
  end
endmodule

// [dv/daisy_link_sva.sv]
// Port assertions for the daisy-chain link block.
`timescale 1ns/1ps
module daisy_link_sva #(
  parameter CNT_W = 10
) (
  input wire clk,
  input wire arst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire lower_rx_negative_input,
  input wire upper_rx_negative_input,
  input wire lower_tx_p,
  input wire lower_tx_n,
  input wire upper_tx_p,
  input wire upper_tx_n,
  input wire shutdown_input_low,
  input wire shutdown_pulldown_en,
  input wire regulator_en,
  input wire high_voltage_en
);
  reg lo_seen, up_seen, lo_q, up_q;
  // A rise on a negative input is the earliest moment a start bit can exist.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {lo_seen, up_seen, lo_q, up_q} <= 4'h0;
    end else begin
      lo_q <= lower_rx_negative_input;
      up_q <= upper_rx_negative_input;
      lo_seen <= lo_seen | (lower_rx_negative_input & ~lo_q);
      up_seen <= up_seen | (upper_rx_negative_input & ~up_q);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_one_pulse: assert property (s_taken |=> s_ack_pulse) else $error("ack timing wrong");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
  a_regulator_follows: assert property (regulator_en == !shutdown_input_low) else $error("regulator wrong");
  a_hv_off_shutdown: assert property (shutdown_input_low |-> !high_voltage_en) else $error("hv on");
  a_pulldown_by_write: assert property ($changed(shutdown_pulldown_en) |-> wb_ack_o || $past(wb_ack_o))
    else $error("pulldown moved alone");
  a_lower_no_clash: assert property (!(lower_tx_p && lower_tx_n)) else $error("lower tx both high");
  a_upper_no_clash: assert property (!(upper_tx_p && upper_tx_n)) else $error("upper tx both high");
  a_upper_silent_unlocked: assert property (!lo_seen |-> !upper_tx_p && !upper_tx_n)
    else $error("upper tx early");
  a_lower_silent_unlocked: assert property (!up_seen |-> !lower_tx_p && !lower_tx_n)
    else $error("lower tx early");
endmodule
bind daisy_chain_uart_link daisy_link_sva #(.CNT_W(CNT_W)) daisy_link_sva_i (.clk(clk), .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .lower_rx_negative_input(lower_rx_negative_input),
  .upper_rx_negative_input(upper_rx_negative_input), .lower_tx_p(lower_tx_p), .lower_tx_n(lower_tx_n),
  .upper_tx_p(upper_tx_p), .upper_tx_n(upper_tx_n), .shutdown_input_low(shutdown_input_low),
  .shutdown_pulldown_en(shutdown_pulldown_en), .regulator_en(regulator_en), .high_voltage_en(high_voltage_en));

// [dv/tb_top.sv]
// Self-checking bench for the daisy-chain link block.
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, se = 1'b0, shd = 1'b0, chk = 1'b0;
  reg [3:0] adr = 4'h0, sel = 4'hF;
  reg [31:0] wdat = 32'h0, rdat, cfg;
  reg [11:0] frame = 12'h0, exp_f = 12'h0, f;
  reg [6:0] bit_cyc = 7'd25;
  integer num_errors = 0, n_compared = 0;
  wire [31:0] dat_o;
  wire ack, lrp, lrn, ltp, ltn, loe, utp, utn, uoe, pd, reg_en, hv_en, busy, mid;
  wire [3:0] idx;
  // The upper port is looped back externally; a floating pin reads low.
  daisy_chain_uart_link daisy_chain_uart_link_i (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .lower_rx_positive_input(lrp), .lower_rx_negative_input(lrn), .upper_rx_positive_input(uoe & utp),
    .upper_rx_negative_input(uoe & utn), .lower_tx_p(ltp), .lower_tx_n(ltn), .lower_tx_oe(loe), .upper_tx_p(utp),
    .upper_tx_n(utn), .upper_tx_oe(uoe), .shutdown_input_low(shd), .shutdown_pulldown_en(pd),
    .regulator_en(reg_en), .high_voltage_en(hv_en));
  chain_host_model chain_host_model_i (.clk(clk), .arst_n(arst_n), .go(go), .frame(frame), .bit_cyc(bit_cyc),
    .single_ended(se), .busy(busy), .mid(mid), .idx(idx), .rx_p(lrp), .rx_n(lrn));
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED %0s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    integer k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    @(posedge clk);
    while (ack !== 1'b1 && k < 50) begin
      @(posedge clk);
      k = k + 1;
    end
    if (k == 50) num_errors = num_errors + 1;
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check("register", e, rdat);
  endtask
  function automatic [11:0] dchar(input [3:0] n, input p);
    dchar = {2'b11, p, ~n[3], n[3], ~n[2], n[2], ~n[1], n[1], ~n[0], n[0], 1'b0};
  endfunction
  function automatic [11:0] fchar(input [7:0] v);
    fchar = {3'b111, v, 1'b0};
  endfunction
  task send(input logic [11:0] c, input logic watch);
    integer k;
    @(posedge clk);
    frame <= c;
    exp_f <= c;
    chk <= watch;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (k = 0; busy === 1'b1 && k < 2000; k = k + 1) @(posedge clk);
    chk <= 1'b0;
  endtask
  task traffic;
    send(fchar(8'h15), 1'b0);
    send(fchar(8'h15), 1'b0);
    send(dchar(4'($urandom), 1'b0), 1'b1);
    send(fchar(8'h54), 1'b1);
  endtask
  always @(posedge clk) begin
    if (chk && mid && idx != 4'd0) begin
      check("upper_tx", {31'h0, exp_f[idx - 4'd1]}, {31'h0, utp});
      // Every hop ends its relay in the middle of the last stop bit.
      if (idx != 4'd12) begin
        check("lower_tx", {31'h0, exp_f[idx - 4'd1]}, {31'h0, ltp});
      end
    end
  end
  task end_sim;
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    #2000000;
    num_errors = num_errors + 1;
    end_sim;
  end
  initial begin
    void'($urandom(98934));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rd(4'h0, 32'h0);
    rd(4'h8, 32'h0);
    rd(4'hC, 32'h0);
    cfg = $urandom & 32'h13;
    wb(1'b1, 4'h0, cfg);
    rd(4'h0, cfg);
    check("pulldown", {31'h0, cfg[4]}, {31'h0, pd});
    check("oe", {30'h0, ~cfg[1:0]}, {30'h0, uoe, loe});
    wb(1'b1, 4'h0, 32'h4);
    rd(4'h0, 32'h4);
    wb(1'b1, 4'h0, 32'h0);
    traffic;
    check("idle", 32'h0, {30'h0, utp, utn});
    f = dchar({2'($urandom), 2'b01}, 1'b0);
    f[2] = f[1];
    f[4] = f[3];
    send(f, 1'b0);
    rd(4'h4, 32'h10);
    wb(1'b1, 4'h4, 32'h10);
    send(dchar(4'($urandom), 1'b1), 1'b0);
    rd(4'h4, 32'h4);
    shd <= 1'b1;
    repeat (4) @(posedge clk);
    rd(4'h4, 32'h24);
    check("power", 32'h0, {30'h0, reg_en, hv_en});
    shd <= 1'b0;
    wb(1'b1, 4'h0, 32'h8);
    rd(4'h4, 32'h0);
    se <= 1'b1;
    bit_cyc <= 7'd50;
    traffic;
    rd(4'h8, 32'h1);
    end_sim;
  end
endmodule

// [hdl/daisy_chain_uart_link.v]
// Daisy-chain UART port logic: relay, rate and mode detection, checks and shutdown control.
// Notes on behaviour
// - Lower receive data is relayed straight to the upper transmitter, unbuffered.
// - Upper receive data, looped on the top device, is relayed to the lower transmitter.
// - Bit rate of 2, 1 or 0.5 Mb/s is learned from first preamble after reset.
// - Each transmitter is silent until the opposite receiver has locked its rate.
// - Idle transmitters drive both outputs low, or float when float-idle bit is 1.
// - Receivers start differential; first preamble may switch to single-ended until reset.
// - Fault status shows per-port mode: 0 differential, 1 single-ended.
// - Open positive input is seen as single-ended and sets that flag.
// - Loopback select 1 routes upper transmit data to upper receiver internally.
// - Every character is twelve bit periods: start, eight payload, parity, two stops.
// - Preamble is 15h with parity one; any other non-stop pattern is data.
// - Data characters carry one nibble, sent least significant first.
// - Each payload bit is followed by its complement; violations set Manchester error.
// - Data parity is zero; a mismatch sets the parity error flag.
// - Soft reset bit resets all registers and disables high-voltage operation.
// - Forced-shutdown bit enables the pull-down on the shutdown input.
// - Low shutdown input sets the alert flag and disables the regulator.
// - Stop character is 54h with parity one, ending a packet.
// - Data bit order: start, four true/inverted pairs, parity zero, two stops.
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "daisy_link_defines.vh"
module daisy_chain_uart_link #(
  parameter CNT_W = 10
) (
  input wire clk,
  input wire arst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire lower_rx_positive_input,
  input wire lower_rx_negative_input,
  input wire upper_rx_positive_input,
  input wire upper_rx_negative_input,
  output wire lower_tx_p,
  output wire lower_tx_n,
  output wire lower_tx_oe,
  output wire upper_tx_p,
  output wire upper_tx_n,
  output wire upper_tx_oe,
  input wire shutdown_input_low,
  output wire shutdown_pulldown_en,
  output wire regulator_en,
  output wire high_voltage_en
);
  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  reg lower_tx_float_idle;
  reg upper_tx_float_idle;
  reg internal_loopback_select;
  reg software_shutdown_pulldown_bit;
  reg soft_reset_request_bit;
  reg manchester_error_flag;
  reg parity_error_flag;
  reg shutdown_alert_flag;
  wire lower_rx_single_ended_flag;
  wire upper_rx_single_ended_flag;
  wire lower_man_err, lower_par_err, upper_man_err, upper_par_err;
  wire lower_locked, upper_locked;
  wire lower_line, upper_line, lower_busy, upper_busy;
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_cfg = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `ADDR_CONFIG);
  wire wr_status = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `ADDR_STATUS);
  // Soft reset acts one cycle after the write, clearing every register.
  wire soft_clear = soft_reset_request_bit;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lower_tx_float_idle <= 1'b0;
      upper_tx_float_idle <= 1'b0;
      internal_loopback_select <= 1'b0;
      software_shutdown_pulldown_bit <= 1'b0;
      soft_reset_request_bit <= 1'b0;
      manchester_error_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      shutdown_alert_flag <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (soft_clear) begin
        lower_tx_float_idle <= 1'b0;
        upper_tx_float_idle <= 1'b0;
        internal_loopback_select <= 1'b0;
        software_shutdown_pulldown_bit <= 1'b0;
        soft_reset_request_bit <= 1'b0;
        manchester_error_flag <= 1'b0;
        parity_error_flag <= 1'b0;
        shutdown_alert_flag <= 1'b0;
      end else begin
        if (wr_cfg) begin
          lower_tx_float_idle <= wb_dat_i[`CFG_LOWER_FLOAT];
          upper_tx_float_idle <= wb_dat_i[`CFG_UPPER_FLOAT];
          internal_loopback_select <= wb_dat_i[`CFG_LOOPBACK];
          soft_reset_request_bit <= wb_dat_i[`CFG_SOFT_RESET];
          software_shutdown_pulldown_bit <= wb_dat_i[`CFG_SHUTDOWN_PULL];
        end
        // Write one to clear; a new event in the same cycle wins.
        manchester_error_flag <= (lower_man_err | upper_man_err) |
          (manchester_error_flag & ~(wr_status & wb_dat_i[`ST_MANCHESTER]));
        parity_error_flag <= (lower_par_err | upper_par_err) |
          (parity_error_flag & ~(wr_status & wb_dat_i[`ST_PARITY]));
        shutdown_alert_flag <= shutdown_input_low |
          (shutdown_alert_flag & ~(wr_status & wb_dat_i[`ST_SHUTDOWN]));
      end
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `ADDR_CONFIG: wb_dat_o <= {27'h0000000, software_shutdown_pulldown_bit, soft_reset_request_bit,
            internal_loopback_select, upper_tx_float_idle, lower_tx_float_idle};
          `ADDR_STATUS: wb_dat_o <= {26'h0000000, shutdown_alert_flag, manchester_error_flag, 1'b0,
            parity_error_flag, 2'b00};
          `ADDR_FAULT_ONE: wb_dat_o <= {30'h00000000, upper_rx_single_ended_flag,
            lower_rx_single_ended_flag};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
  assign shutdown_pulldown_en = software_shutdown_pulldown_bit;
  assign regulator_en = ~shutdown_input_low;
  assign high_voltage_en = ~soft_reset_request_bit & ~shutdown_input_low;
  // -----------------------------------------------------------------------
  // Receivers
  // -----------------------------------------------------------------------
  // Loopback on: the upper receiver hears the upper transmitter, pins ignored.
  wire upper_p = internal_loopback_select ? upper_tx_p : upper_rx_positive_input;
  wire upper_n = internal_loopback_select ? upper_tx_n : upper_rx_negative_input;
  daisy_port_receiver #(.CNT_W(CNT_W)) u_lower_rx (
    .clk(clk),
    .arst_n(arst_n),
    .soft_clear(soft_clear),
    .rx_p(lower_rx_positive_input),
    .rx_n(lower_rx_negative_input),
    .line(lower_line),
    .busy(lower_busy),
    .locked(lower_locked),
    .single_ended(lower_rx_single_ended_flag),
    .man_err(lower_man_err),
    .par_err(lower_par_err)
  );
  daisy_port_receiver #(.CNT_W(CNT_W)) u_upper_rx (
    .clk(clk),
    .arst_n(arst_n),
    .soft_clear(soft_clear),
    .rx_p(upper_p),
    .rx_n(upper_n),
    .line(upper_line),
    .busy(upper_busy),
    .locked(upper_locked),
    .single_ended(upper_rx_single_ended_flag),
    .man_err(upper_man_err),
    .par_err(upper_par_err)
  );
  // -----------------------------------------------------------------------
  // Transmitters
  // -----------------------------------------------------------------------
  // The decoded line is relayed bit by bit, so no character is buffered.
  // A relayed start bit shows as n high and p low, which the next receiver
  // tells apart from the idle state with both outputs low.
  wire upper_active = lower_locked & lower_busy;
  wire lower_active = upper_locked & upper_busy;
  assign upper_tx_p = upper_active & lower_line;
  assign upper_tx_n = upper_active & ~lower_line;
  assign upper_tx_oe = upper_active | ~upper_tx_float_idle;
  assign lower_tx_p = lower_active & upper_line;
  assign lower_tx_n = lower_active & ~upper_line;
  assign lower_tx_oe = lower_active | ~lower_tx_float_idle;
endmodule
// -------------------------------------------------------------------------
// One port receiver
// -------------------------------------------------------------------------
module daisy_port_receiver #(
  parameter CNT_W = 10
) (
  input wire clk,
  input wire arst_n,
  input wire soft_clear,
  input wire rx_p,
  input wire rx_n,
  output wire line,
  output wire busy,
  output reg locked,
  output reg single_ended,
  output reg man_err,
  output reg par_err
);
  localparam S_IDLE = 2'd0;
  localparam S_MEASURE = 2'd1;
  localparam S_FRAME = 2'd2;
  localparam S_SKIP = 2'd3;
  reg [1:0] state;
  reg [CNT_W-1:0] cnt;
  reg [CNT_W-1:0] period;
  reg [3:0] bit_idx;
  reg [11:0] shreg;
  reg seen_first;
  reg rx_q;
  // -----------------------------------------------------------------------
  // Line decode
  // -----------------------------------------------------------------------
  // Differential: idle (both low) and mark both read as one, a space as zero.
  // Single-ended: the positive input is ignored and data is taken from ~rx_n.
  assign line = single_ended ? ~rx_n : (rx_p | ~rx_n);
  // Only a real character is relayed; the locking preamble is swallowed.
  assign busy = (state == S_FRAME);
  wire [11:0] word = {line, shreg[11:1]};
  wire [7:0] payload = word[8:1];
  wire is_pre = (payload == `PREAMBLE_PATTERN) & word[9];
  wire is_stop = (payload == `STOP_PATTERN) & word[9];
  wire pairs_ok = (payload[0] ^ payload[1]) & (payload[2] ^ payload[3]) &
    (payload[4] ^ payload[5]) & (payload[6] ^ payload[7]);
  wire half = (cnt == {1'b0, period[CNT_W-1:1]});
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      cnt <= {CNT_W{1'b0}};
      period <= {CNT_W{1'b0}};
      bit_idx <= 4'h0;
      shreg <= 12'h000;
      locked <= 1'b0;
      single_ended <= 1'b0;
      seen_first <= 1'b0;
      man_err <= 1'b0;
      par_err <= 1'b0;
      rx_q <= 1'b0;
    end else if (soft_clear) begin
      state <= S_IDLE;
      locked <= 1'b0;
      single_ended <= 1'b0;
      seen_first <= 1'b0;
      man_err <= 1'b0;
      par_err <= 1'b0;
    end else begin
      rx_q <= line;
      man_err <= 1'b0;
      par_err <= 1'b0;
      case (state)
        S_IDLE: begin
          cnt <= {CNT_W{1'b0}};
          if (rx_q && !line) begin
            state <= locked ? S_FRAME : S_MEASURE;
            bit_idx <= 4'h0;
          end
        end
        S_MEASURE: begin
          // The preamble starts with a zero bit then a one: time the start bit.
          cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
          if (line) begin
            period <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
            // The first data bit of the preamble is a one on the positive input in
            // differential mode; a grounded or open positive input stays low.
            if (!seen_first) begin
              single_ended <= ~rx_p;
            end
            seen_first <= 1'b1;
            locked <= 1'b1;
            // Sit out the rest of the locking preamble, one cycle into its first data bit.
            state <= S_SKIP;
            cnt <= {{(CNT_W-1){1'b0}}, 1'b1};
            bit_idx <= 4'h1;
            shreg <= 12'h000;
          end
        end
        S_FRAME, S_SKIP: begin
          if (half) begin
            shreg <= word;
            bit_idx <= bit_idx + 4'h1;
          end
          if (cnt == period - {{(CNT_W-1){1'b0}}, 1'b1}) begin
            cnt <= {CNT_W{1'b0}};
          end else begin
            cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
          end
          if (half && bit_idx == `CHAR_BITS - 1) begin
            state <= S_IDLE;
            if (state == S_FRAME && !is_pre && !is_stop) begin
              man_err <= ~pairs_ok;
              par_err <= word[9] | ~word[10] | ~word[11];
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// [hdl/daisy_link_defines.vh]
// Constants for the daisy-chain UART port logic.
`ifndef DAISY_LINK_DEFINES_VH
`define DAISY_LINK_DEFINES_VH
// -------------------------------------------------------------------------
// Register byte addresses
// -------------------------------------------------------------------------
`define ADDR_CONFIG 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_FAULT_ONE 4'h8
// -------------------------------------------------------------------------
// Config fields
// -------------------------------------------------------------------------
`define CFG_LOWER_FLOAT 0
`define CFG_UPPER_FLOAT 1
`define CFG_LOOPBACK 2
`define CFG_SOFT_RESET 3
`define CFG_SHUTDOWN_PULL 4
// -------------------------------------------------------------------------
// Status and fault fields
// -------------------------------------------------------------------------
`define ST_PARITY 2
`define ST_MANCHESTER 4
`define ST_SHUTDOWN 5
`define FLT_LOWER_SE 0
`define FLT_UPPER_SE 1
// -------------------------------------------------------------------------
// Characters and timing
// -------------------------------------------------------------------------
`define PREAMBLE_PATTERN 8'h15
`define STOP_PATTERN 8'h54
`define CHAR_BITS 12
`define BAUD_FAST_CYC 10'h000
`endif
